// ---- dv/mbus_host_properties.sv ----
// Checker: pin-level timing relations of the muxed-bus host controller
`timescale 1ns/100ps
module mbus_host_properties (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire mbus_pkg::pins_s    pins
);
  import mbus_pkg::*;
  // ----------------------------------------
  // Clocking and named steps
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence wr_held; !pins.write_strobe_n [*4]; endsequence
  sequence strobe_any; !pins.read_strobe_n || !pins.write_strobe_n ||
    !pins.program_fetch_strobe_n; endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rd_excl_a: assert property (!pins.read_strobe_n |->
    pins.write_strobe_n && pins.program_fetch_strobe_n) else $error("read strobe overlap");
  fetch_excl_a: assert property (!pins.program_fetch_strobe_n |->
    pins.read_strobe_n && pins.write_strobe_n) else $error("fetch strobe overlap");
  cs_early_a: assert property ($fell(pins.ale) |->
    !pins.chip_sel_n && $past(!pins.chip_sel_n)) else $error("select late");
  addr_latch_a: assert property ($fell(pins.ale) |->
    pins.ad_oe && $stable(pins.upper_address_inputs)) else $error("address not held");
  ale_quiet_a: assert property (pins.ale |-> not strobe_any)
    else $error("strobe during latch");
  wr_len_a: assert property ($fell(pins.write_strobe_n) |-> wr_held)
    else $error("write strobe short");
  wr_data_a: assert property (!pins.write_strobe_n && $past(!pins.write_strobe_n) |->
    pins.ad_oe && $stable(pins.ad_out)) else $error("write data moved");
  bus_free_a: assert property (!pins.read_strobe_n || !pins.program_fetch_strobe_n |->
    !pins.ad_oe) else $error("bus contention");
  strobe_cs_a: assert property (strobe_any |-> !pins.chip_sel_n)
    else $error("strobe without select");
endmodule : mbus_host_properties

bind mbus_host mbus_host_properties u_props (
  .clock   (clock),
  .reset_n (reset_n),
  .pins    (pins)
);

// ---- dv/nv_mem_model.sv ----
// Behavioural model of the muxed-bus nonvolatile memory device
`timescale 1ns/100ps
module nv_mem_model (
  input  wire mbus_pkg::pins_s pins,
  input  wire logic [7:0]      bus,
  input  wire logic [7:0]      lock,
  output logic      [7:0]      dout
);
  import mbus_pkg::*;
  logic [7:0]        mem [MEM_BYTES];
  logic [ADDR_W-1:0] lat;
  logic              sel;
  logic [7:0]        last;
  logic              drive;
  int unsigned       wr_count;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [7:0]        wr_old;
  logic              wr_done = 1'b0;
  realtime           t_rise;
  // Transparent latch while ale high, frozen on its fall
  always_latch if (pins.ale) begin
    lat = {pins.upper_address_inputs, bus};
    sel = !pins.chip_sel_n;
  end
  // Output enable: fetch or read decode, standby when deselected
  assign drive = sel && !pins.chip_sel_n && pins.write_strobe_n &&
    (pins.program_fetch_strobe_n != pins.read_strobe_n);
  always @* if (drive) last = mem[lat];
  assign dout = drive ? mem[lat] : ~last; // Released bus shows inverse
  // Data taken on rising write strobe; locked or uncommitted writes vanish
  always @(posedge pins.write_strobe_n) begin
    if (sel && !pins.chip_sel_n && pins.read_strobe_n) begin
      wr_count++;
      wr_addr = lat;
      wr_data = bus;
      t_rise  = $realtime;
      wr_done = 1'b0;
      if (!pins.write_commit_n && !lock[lat[12:10]]) begin
        wr_old   = mem[lat];
        wr_done  = 1'b1;
        mem[lat] = bus;
      end
    end
  end
  // Commit raised soon after the last write cancels that write
  always @(posedge pins.write_commit_n) begin
    if (wr_done && ($realtime - t_rise) <= COMMIT_NS) mem[wr_addr] = wr_old;
    wr_done = 1'b0;
  end
endmodule : nv_mem_model

// ---- dv/tb_mbus_host.sv ----
// Testbench: register-level tests of the muxed-bus host controller
`timescale 1ns/100ps
module tb_mbus_host;
  import mbus_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  sw_req_s     sw_req = '0;
  logic [31:0] sw_rdata;
  logic [7:0]  ad_in;
  logic [7:0]  dev_out;
  logic [7:0]  lock = 8'h00;
  pins_s       pins;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [31:0] q;

  always #5 clock = ~clock;
  assign ad_in = pins.ad_oe ? pins.ad_out : dev_out;

  mbus_host u_dut (.clock(clock), .reset_n(reset_n), .clk_en(1'b1), .sw_req(sw_req),
    .sw_rdata(sw_rdata), .ad_in(ad_in), .pins(pins));
  nv_mem_model u_model (.pins(pins), .bus(ad_in), .lock(lock), .dout(dev_out));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    sw_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    sw_req <= '0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    sw_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    sw_req <= '0;
    #1 q = sw_rdata;
    @(posedge clock);
  endtask : rd
  task automatic wait_idle;
    int i;
    for (i = 0; i < 200; i++) begin
      rd(REG_STATUS);
      if (q[0] === 1'b0) break;
    end
    chk("busy", q[0], 1'b0);
  endtask : wait_idle
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
  endtask : do_reset
  // Write one byte with n guard bytes ahead; returns bus writes seen
  task automatic do_write(input logic [12:0] a, input logic [7:0] d,
                          input logic [31:0] extra, input int n, output int seen);
    int c0;
    int i;
    c0 = u_model.wr_count;
    wr(REG_SEQ, n);
    wr(REG_ADDR, {19'h0, a});
    wr(REG_WDATA, {24'h0, d});
    wr(REG_CTRL, extra | (32'h1 << CTRL_WRITE));
    for (i = 0; i < 300 && u_model.wr_count < c0 + n + 1; i++) @(posedge clock);
    repeat (30) @(posedge clock);
    seen = u_model.wr_count - c0;
  endtask : do_write
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #300000;
    num_errors++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int m;
    int k;
    int seen;
    logic [12:0] a;
    for (k = 0; k < MEM_BYTES; k++) u_model.mem[k] = k[7:0] ^ 8'hA5;
    do_reset();
    #1;
    chk("cs idle", pins.chip_sel_n, 1'b1);
    chk("bus idle", pins.ad_oe, 1'b0);
    @(posedge clock);
    rd(4'h7);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    // Reads via data strobe and fetch strobe at both ends of the map
    for (m = 0; m < 4; m++) begin
      a = m[0] ? 13'h1FFF : 13'h0000;
      u_model.mem[a] = 8'h3C + m[7:0];
      wr(REG_ADDR, {19'h0, a});
      wr(REG_CTRL, 32'h1 << (m[1] ? CTRL_FETCH : CTRL_READ));
      wait_idle();
      rd(REG_RDATA);
      chk("read byte", q[7:0], 8'h3C + m[7:0]);
    end
    wr(REG_CTRL, (32'h1 << CTRL_READ) | (32'h1 << CTRL_POLL));
    wait_idle();
    rd(REG_STATUS);
    chk("toggle idle", q[4], 1'b0);
    rd(REG_RDATA);
    chk("poll byte", q[7:0], 8'h3F);
    $display("test read done");
    // Plain write lands at the latched address
    do_write(13'h0ABC, 8'h5A, 32'h0, 0, seen);
    chk("write count", seen, 1);
    chk("write addr", u_model.wr_addr, 13'h0ABC);
    chk("write mem", u_model.mem[13'h0ABC], 8'h5A);
    do_reset();
    $display("test write done");
    // Guarded write into a locked block leaves memory alone
    for (k = 0; k < 6; k++) wr(4'h8 + k[3:0], {11'h0, 13'h1555 ^ k[12:0], 8'hA0 + k[7:0]});
    lock <= 8'h04;
    do_write(13'h0ABC, 8'hC3, 32'h0, 3, seen);
    chk("guard count", seen, 4);
    chk("guard data", u_model.wr_data, 8'hC3);
    chk("locked mem", u_model.mem[13'h0ABC], 8'h5A);
    do_reset();
    do_write(13'h0ABD, 8'h3E, 32'h0, 6, seen);
    chk("lock seq count", seen, 7);
    chk("lock seq mem", u_model.mem[13'h0ABD], 8'hBD ^ 8'hA5);
    do_reset();
    $display("test lock done");
    // Inhibited commit keeps an unlocked byte unchanged
    lock <= 8'h00;
    do_write(13'h0010, 8'h77, 32'h1 << CTRL_INHIB, 0, seen);
    chk("inhibit mem", u_model.mem[13'h0010], 8'h10 ^ 8'hA5);
    do_reset();
    $display("test inhibit done");
    // Commit raised right after the write strobe cancels the byte
    wr(REG_ADDR, 32'h20);
    wr(REG_WDATA, 32'h99);
    wr(REG_CTRL, 32'h1 << CTRL_WRITE);
    wr(REG_CTRL, 32'h1 << CTRL_ABORT);
    repeat (40) @(posedge clock);
    rd(REG_STATUS);
    chk("abort flags", q[1:0], 2'h2);
    chk("abort mem", u_model.mem[13'h0020], 8'h20 ^ 8'hA5);
    $display("test abort done");
    // Page bytes share their upper address; a stray page is refused
    do_write(13'h0100, 8'h11, 32'h1 << CTRL_PAGE, 0, seen);
    do_write(13'h0101, 8'h22, 32'h1 << CTRL_PAGE, 0, seen);
    chk("page count", seen, 1);
    do_write(13'h0200, 8'h33, 32'h1 << CTRL_PAGE, 0, seen);
    chk("page stray", seen, 0);
    rd(REG_STATUS);
    chk("page status", q[7:0], 8'h44);
    chk("page mem", u_model.mem[13'h0101], 8'h22);
    do_reset();
    $display("test page done");
    summarize();
  end
endmodule : tb_mbus_host

// ---- hdl/mbus_host.sv ----
// Host controller driving the muxed-bus nonvolatile memory through its pins
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module mbus_host (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire mbus_pkg::sw_req_s     sw_req,
  output logic      [31:0]           sw_rdata,
  input  wire logic [7:0]            ad_in,
  output mbus_pkg::pins_s            pins
);
  import mbus_pkg::*;

  typedef struct packed {
    cyc_e              st;
    pins_s             pins;
    logic [31:0]       rdata;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] cur_addr;
    logic [7:0]        wdata;
    logic [7:0]        cur_data;
    logic [7:0]        last_rd;
    logic              is_read;
    logic              is_fetch;
    logic              page;
    logic              inhibit;
    logic              poll;
    logic              busy;
    logic              abort_req;
    logic              aborted;
    logic              page_err;
    logic              prog_done;
    logic              toggling;
    logic [2:0]        seq_len;
    logic [2:0]        seq_idx;
    logic              in_seq;
    logic [4:0]        page_cnt;
    logic [ADDR_W-6:0] page_base;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  gap;
  } state_s;

  state_s      s_r;
  state_s      s_nxt;
  logic [20:0] seq_rdata;
  logic        seq_we;

  localparam logic [CNT_W-1:0] PHASE_N  = CNT_W'(PHASE_CYC);
  localparam logic [CNT_W-1:0] GAP_N    = CNT_W'(PAGE_GAP_CYC);
  localparam logic [CNT_W-1:0] COMMIT_N = CNT_W'(COMMIT_CYC);
  localparam logic [CNT_W-1:0] PROG_N   = CNT_W'(PROG_CYC);

  assign seq_we = sw_req.wr && (sw_req.addr[3] == 1'b1);

  // ---------------------------------------------------------------
  // Command sequence store (guard three bytes, lock six bytes)
  // ---------------------------------------------------------------
  seq_mem u_seq (
    .clock  (clock),
    .clk_en (clk_en),
    .we     (seq_we),
    .waddr  (sw_req.addr[2:0]),
    .wdata  (sw_req.wdata[20:0]),
    .raddr  (s_nxt.seq_idx),
    .rdata  (seq_rdata)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - CNT_W'(1);
    end
    if (s_r.gap != '0) begin
      s_nxt.gap = s_r.gap - CNT_W'(1);
    end
    // Software register access
    if (sw_req.wr && sw_req.addr == REG_CTRL && !s_r.busy) begin
      s_nxt.is_read   = sw_req.wdata[CTRL_READ] | sw_req.wdata[CTRL_FETCH];
      s_nxt.is_fetch  = sw_req.wdata[CTRL_FETCH];
      s_nxt.poll      = sw_req.wdata[CTRL_POLL];
      s_nxt.page      = sw_req.wdata[CTRL_PAGE];
      s_nxt.inhibit   = sw_req.wdata[CTRL_INHIB];
      s_nxt.busy      = |sw_req.wdata[CTRL_POLL:0] & ~sw_req.wdata[CTRL_ABORT];
      s_nxt.in_seq    = sw_req.wdata[CTRL_WRITE] && s_r.seq_len != 3'h0;
      s_nxt.seq_idx   = 3'h0;
      s_nxt.aborted   = 1'b0;
      s_nxt.page_err  = 1'b0;
      s_nxt.prog_done = 1'b0;
      s_nxt.toggling  = 1'b0;
    end
    if (sw_req.wr && sw_req.addr == REG_CTRL && sw_req.wdata[CTRL_ABORT]) begin
      s_nxt.abort_req = 1'b1;
    end
    if (sw_req.wr && sw_req.addr == REG_ADDR) begin
      s_nxt.addr = sw_req.wdata[ADDR_W-1:0];
    end
    if (sw_req.wr && sw_req.addr == REG_WDATA) begin
      s_nxt.wdata = sw_req.wdata[7:0];
    end
    if (sw_req.wr && sw_req.addr == REG_SEQ) begin
      s_nxt.seq_len = sw_req.wdata[2:0]; // 0, 3 or 6 bytes
    end
    if (sw_req.rd) begin
      case (sw_req.addr)
        REG_ADDR:   s_nxt.rdata = {19'h0, s_r.addr};
        REG_WDATA:  s_nxt.rdata = {24'h0, s_r.wdata};
        REG_RDATA:  s_nxt.rdata = {24'h0, s_r.last_rd};
        REG_STATUS: s_nxt.rdata = {24'h0, s_r.page_cnt[2:0], s_r.toggling,
                                   s_r.prog_done, s_r.page_err, s_r.aborted, s_r.busy};
        REG_SEQ:    s_nxt.rdata = {29'h0, s_r.seq_len};
        default:    s_nxt.rdata = '0;
      endcase
    end
    // Pin sequencer
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.pins.ad_oe = 1'b0;
        if (s_r.busy && !s_r.abort_req) begin
          if (s_r.in_seq) begin
            s_nxt.cur_addr = seq_rdata[20:8];
            s_nxt.cur_data = seq_rdata[7:0];
          end else begin
            s_nxt.cur_addr = s_r.addr;
            s_nxt.cur_data = s_r.wdata;
          end
          s_nxt.pins.chip_sel_n = 1'b0;
          s_nxt.pins.ale        = 1'b1;
          s_nxt.cnt             = PHASE_N;
          s_nxt.st              = ST_ALE;
        end else if (s_r.abort_req) begin
          s_nxt.abort_req = 1'b0;
          s_nxt.busy      = 1'b0;
        end
      end
      ST_ALE: begin
        // Latch is transparent: present full address while strobe high
        s_nxt.pins.upper_address_inputs = s_r.cur_addr[ADDR_W-1:8];
        s_nxt.pins.ad_out               = s_r.cur_addr[7:0];
        s_nxt.pins.ad_oe                = 1'b1;
        if (s_r.cnt == '0) begin
          s_nxt.pins.ale = 1'b0;
          s_nxt.cnt      = PHASE_N;
          s_nxt.st       = ST_ALE_LOW;
        end
      end
      ST_ALE_LOW: begin
        if (s_r.cnt == '0) begin
          s_nxt.cnt = PHASE_N;
          if (s_r.is_read) begin
            s_nxt.pins.ad_oe = 1'b0;
            if (s_r.is_fetch) begin
              s_nxt.pins.program_fetch_strobe_n = 1'b0;
            end else begin
              s_nxt.pins.read_strobe_n = 1'b0;
            end
            s_nxt.st = ST_RD_LOW;
          end else if (s_r.page && !s_r.in_seq &&
                       s_r.page_cnt != 5'h0 &&
                       s_r.cur_addr[ADDR_W-1:5] != s_r.page_base) begin
            s_nxt.page_err = 1'b1;
            s_nxt.busy     = 1'b0;
            s_nxt.pins.chip_sel_n = 1'b1;
            s_nxt.st       = ST_IDLE;
          end else begin
            s_nxt.pins.ad_out         = s_r.cur_data;
            s_nxt.pins.write_strobe_n = 1'b0;
            s_nxt.gap                 = GAP_N;
            s_nxt.st                  = ST_WR_LOW;
          end
        end
      end
      ST_RD_LOW: begin
        if (s_r.cnt == '0) begin
          s_nxt.last_rd                     = ad_in;
          s_nxt.pins.read_strobe_n          = 1'b1;
          s_nxt.pins.program_fetch_strobe_n = 1'b1;
          s_nxt.st                          = ST_RD_END;
          if (s_r.poll) begin
            // Bit six still flipping means programming runs on
            s_nxt.toggling = ((ad_in ^ s_r.last_rd) & TOGGLE_BIT_MASK) != 8'h00;
          end
        end
      end
      ST_RD_END: begin
        s_nxt.pins.chip_sel_n = 1'b1;
        s_nxt.busy            = s_r.poll && s_r.toggling && s_r.cnt == '0;
        s_nxt.st              = ST_IDLE;
      end
      ST_WR_LOW: begin
        if (s_r.cnt == '0) begin
          s_nxt.pins.write_strobe_n = 1'b1;
          s_nxt.cnt                 = PHASE_N;
          s_nxt.st                  = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (s_r.cnt == '0) begin
          s_nxt.pins.ad_oe      = 1'b0;
          s_nxt.pins.chip_sel_n = 1'b1;
          if (s_r.in_seq && s_r.seq_idx + 3'h1 < s_r.seq_len) begin
            s_nxt.seq_idx = s_r.seq_idx + 3'h1;
            s_nxt.st      = ST_IDLE;
          end else if (s_r.in_seq) begin
            s_nxt.in_seq = 1'b0; // Sequence sent, now the data byte
            s_nxt.st     = ST_IDLE;
          end else if (s_r.page && s_r.page_cnt != 5'(PAGE_BYTES - 1)) begin
            // Wait for software to queue next page byte
            s_nxt.page_base = s_r.cur_addr[ADDR_W-1:5];
            s_nxt.page_cnt  = s_r.page_cnt + 5'h1;
            s_nxt.busy      = 1'b0;
            s_nxt.st        = ST_COMMIT;
          end else begin
            s_nxt.cnt = COMMIT_N;
            s_nxt.st  = ST_COMMIT;
          end
        end
      end
      ST_COMMIT: begin
        // Abort window runs COMMIT_N cycles from the write strobe rise
        if (s_r.abort_req && s_r.gap > GAP_N - PHASE_N - CNT_W'(1) - COMMIT_N) begin
          s_nxt.pins.write_commit_n = 1'b1;
          s_nxt.aborted   = 1'b1;
          s_nxt.abort_req = 1'b0;
          s_nxt.busy      = 1'b0;
          s_nxt.page_cnt  = 5'h0;
          s_nxt.cnt       = PHASE_N;
          s_nxt.st        = ST_DONE;
        end else if (s_r.busy && !s_r.in_seq && s_r.page) begin
          s_nxt.st = ST_IDLE; // Next page byte inside the window
        end else if (s_r.gap == '0) begin
          s_nxt.cnt      = PROG_N;
          s_nxt.page_cnt = 5'h0;
          s_nxt.busy     = 1'b1;
          s_nxt.st       = ST_PROG;
        end
      end
      ST_PROG: begin
        // Refused writes give no answer, so only the timeout ends this
        if (s_r.cnt == '0) begin
          s_nxt.prog_done = 1'b1;
          s_nxt.busy      = 1'b0;
          s_nxt.st        = ST_IDLE;
        end
      end
      ST_DONE: begin
        if (s_r.cnt == '0) begin
          s_nxt.pins.write_commit_n = s_r.inhibit;
          s_nxt.st                  = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (s_r.st == ST_IDLE) begin
      s_nxt.pins.write_commit_n = s_nxt.inhibit;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{st: ST_IDLE,
               pins: '{ale: 1'b0, chip_sel_n: 1'b1, read_strobe_n: 1'b1,
                       write_strobe_n: 1'b1, program_fetch_strobe_n: 1'b1,
                       write_commit_n: 1'b1, upper_address_inputs: '0,
                       ad_out: 8'h00, ad_oe: 1'b0},
               default: '0};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign pins     = s_r.pins;
  assign sw_rdata = s_r.rdata;
endmodule : mbus_host

// ---- hdl/mbus_pkg.sv ----
// Package: constants and carrier structs of the muxed-bus memory controller
package mbus_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned MEM_BYTES  = 8192;
  localparam int unsigned BLOCKS     = 8;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned GUARD_LEN  = 3;
  localparam int unsigned LOCK_LEN   = 6;

  // ---------------------------------------------------------------
  // Timing, 100 MHz clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned PHASE_NS      = 40;
  localparam int unsigned PHASE_CYC     = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PAGE_GAP_US   = 100;
  localparam int unsigned PAGE_GAP_CYC  = PAGE_GAP_US * 1000 / CLK_NS;
  localparam int unsigned COMMIT_NS     = 100;
  localparam int unsigned COMMIT_CYC    = (COMMIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PROG_MS       = 5;
  localparam int unsigned PROG_CYC      = PROG_MS * 100000;
  localparam int unsigned CNT_W         = 20;

  // ---------------------------------------------------------------
  // Software register map (word index)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SEQ    = 4'h5;

  // CTRL command bits (self clearing)
  localparam int unsigned CTRL_READ   = 0;
  localparam int unsigned CTRL_WRITE  = 1;
  localparam int unsigned CTRL_FETCH  = 2;
  localparam int unsigned CTRL_ABORT  = 3;
  localparam int unsigned CTRL_POLL   = 4;
  localparam int unsigned CTRL_PAGE   = 5;
  localparam int unsigned CTRL_INHIB  = 6;

  localparam logic [7:0] TOGGLE_BIT_MASK = 8'h40;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                ale;
    logic                chip_sel_n;
    logic                read_strobe_n;
    logic                write_strobe_n;
    logic                program_fetch_strobe_n;
    logic                write_commit_n;
    logic [ADDR_W-9:0]   upper_address_inputs;
    logic [7:0]          ad_out;
    logic                ad_oe;
  } pins_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sw_req_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ALE, ST_ALE_LOW, ST_RD_LOW, ST_RD_END,
    ST_WR_LOW, ST_WR_HIGH, ST_COMMIT, ST_PROG, ST_DONE
  } cyc_e;

endpackage : mbus_pkg

// ---- hdl/seq_mem.sv ----
// Small memory holding the command/lock byte sequence (address:data pairs)
`timescale 1ns/100ps
module seq_mem (
  input  wire logic        clock,
  input  wire logic        clk_en,
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [20:0] wdata,
  input  wire logic [2:0]  raddr,
  output logic      [20:0] rdata
);
  logic [20:0] mem [0:7];

  // ---------------------------------------------------------------
  // Write port and registered read
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : seq_mem
